//--- hw/reference_clock_path.v
`timescale 1ns/100ps
`include "ref_path_consts.vh"

// Function
// - doubler enabled uses both reference edges
// - scaler multiplies by 3 to 7
// - scaler factor 1 passes through
// - pre-divider 1 to 255, 1 bypasses
// - post-divider 1 to 255 gives compare clock
// - compare rate is ref*dbl*scale/(pre*post)
module reference_clock_path #(
    parameter PERIOD_W = 16,
    parameter TIMEOUT_CYC = `REF_TIMEOUT_CYC
) (
    input wire clk_sys,
    input wire rst_b,
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire referenceClockInput,
    output reg phaseCompareClk,
    output reg scalerHighBand,
    output reg calibrationStart
);
    // configuration registers
    reg doublerEnable_q; // reference_doubler_enable
    reg [7:0] preDiv_q; // pre-divider value
    reg [2:0] scalerFactor_q; // frequency_scaler_factor
    reg [7:0] postDiv_q; // post-divider value
    reg calNoRef_q; // sticky: trigger seen with no reference

    // reference edge and presence state
    reg refPrev_q; // previous sample of the reference pin
    reg [PERIOD_W-1:0] refIdle_q; // cycles since last reference edge
    reg refOk_q; // reference toggling within timeout

    // scaler state
    reg [PERIOD_W-1:0] periodCnt_q; // running period count of pre-divided ticks
    reg [PERIOD_W-1:0] period_q; // last measured period
    reg [PERIOD_W+2:0] acc_q; // phase accumulator
    reg [2:0] factor_q; // factor in force for this input period
    reg [2:0] emitted_q; // events produced this input period
    reg scaleTick_q; // scaler output tick

    wire refRise; // rising edge of the sampled reference
    wire refFall; // falling edge of the sampled reference
    wire edgeTick; // doubler output tick
    wire preTick; // pre-divider output tick
    wire postTick; // post-divider output tick
    wire scalerActive; // factor 3..7 selected
    wire busReq; // a bus request is pending
    wire accept; // request completes on this edge
    wire wrLow; // low byte lane write enable
    wire [PERIOD_W+2:0] accNext; // accumulator plus factor
    wire [PERIOD_W+2:0] periodWide; // measured period widened

    assign refRise = referenceClockInput & ~refPrev_q;
    assign refFall = ~referenceClockInput & refPrev_q;
    // both edges count when doubling, the rising edge otherwise
    assign edgeTick = doublerEnable_q ? (refRise | refFall) : refRise;
    assign scalerActive = (scalerFactor_q >= `SCALER_MIN) && (scalerFactor_q <= `SCALER_MAX);
    assign busReq = avs_read | avs_write;
    assign accept = busReq & ~avs_waitrequest;
    assign wrLow = avs_write & accept & avs_byteenable[0];
    assign accNext = acc_q + {{PERIOD_W{1'b0}}, factor_q};
    assign periodWide = {3'h0, period_q};

    // sample reference for edge detection
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            refPrev_q <= 1'b0;
        end else begin
            refPrev_q <= referenceClockInput;
        end
    end

    // reference presence watchdog, saturating idle count
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            refIdle_q <= {PERIOD_W{1'b0}};
            refOk_q <= 1'b0;
        end else begin
            if (refRise | refFall) begin
                refIdle_q <= {PERIOD_W{1'b0}};
                refOk_q <= 1'b1;
            end else if (refIdle_q >= TIMEOUT_CYC[PERIOD_W-1:0]) begin
                refOk_q <= 1'b0; // gone quiet too long
            end else begin
                refIdle_q <= refIdle_q + {{(PERIOD_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // pre-divider on the doubler output
    tick_divider #(
        .DIV_W(8)
    ) u_pre_div (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .tickIn(edgeTick),
        .divValue(preDiv_q),
        .tickOut(preTick)
    );

    // measure pre-divided period in system cycles, saturating
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            periodCnt_q <= {PERIOD_W{1'b0}};
            period_q <= {PERIOD_W{1'b0}};
        end else begin
            if (preTick) begin
                period_q <= periodCnt_q + {{(PERIOD_W-1){1'b0}}, 1'b1};
                periodCnt_q <= {PERIOD_W{1'b0}};
            end else if (periodCnt_q != {PERIOD_W{1'b1}}) begin
                periodCnt_q <= periodCnt_q + {{(PERIOD_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // scaler: spreads factor events over the last measured period
    // output rate is bounded by the system clock; the spacing follows
    // the previous period, so a changing reference settles one period late
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            acc_q <= {(PERIOD_W+3){1'b0}};
            factor_q <= `SCALER_ONE;
            emitted_q <= 3'h0;
            scaleTick_q <= 1'b0;
        end else begin
            scaleTick_q <= 1'b0;
            if (preTick) begin
                // first event of each period aligns to the input tick
                scaleTick_q <= 1'b1;
                acc_q <= {(PERIOD_W+3){1'b0}};
                emitted_q <= 3'h1;
                // factor changes only at an input tick, keeping whole periods
                factor_q <= scalerActive ? scalerFactor_q : `SCALER_ONE;
            end else if (emitted_q < factor_q) begin
                if (accNext >= periodWide) begin
                    scaleTick_q <= 1'b1;
                    acc_q <= accNext - periodWide;
                    emitted_q <= emitted_q + 3'h1;
                end else begin
                    acc_q <= accNext;
                end
            end
        end
    end

    // post-divider forms the phase compare rate
    tick_divider #(
        .DIV_W(8)
    ) u_post_div (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .tickIn(scaleTick_q),
        .divValue(postDiv_q),
        .tickOut(postTick)
    );

    // compare clock: one high cycle per output period
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            phaseCompareClk <= 1'b0;
        end else begin
            phaseCompareClk <= postTick;
        end
    end

    // bus handshake: one wait cycle, then a single-cycle acceptance
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~(busReq & avs_waitrequest);
        end
    end

    // register writes; only the low lane carries fields
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            doublerEnable_q <= 1'b0;
            scalerHighBand <= 1'b0;
            preDiv_q <= `PREDIV_RESET;
            scalerFactor_q <= `SCALER_RESET;
            postDiv_q <= `POSTDIV_RESET;
        end else if (wrLow) begin
            case (avs_address)
                `REG_CTRL: begin
                    doublerEnable_q <= avs_writedata[`CTRL_DOUBLER_BIT];
                    scalerHighBand <= avs_writedata[`CTRL_HIBAND_BIT];
                end
                `REG_PREDIV: begin
                    preDiv_q <= avs_writedata[7:0];
                end
                `REG_SCALER: begin
                    scalerFactor_q <= avs_writedata[2:0];
                end
                `REG_POSTDIV: begin
                    postDiv_q <= avs_writedata[7:0];
                end
                default: begin
                    // unmapped or read-only: ignored
                end
            endcase
        end
    end

    // calibration trigger pulse and missing-reference flag
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            calibrationStart <= 1'b0;
            calNoRef_q <= 1'b0;
        end else begin
            calibrationStart <= 1'b0;
            if (wrLow && avs_address == `REG_CTRL && avs_writedata[`CTRL_CALTRIG_BIT]) begin
                if (refOk_q) begin
                    calibrationStart <= 1'b1;
                end else begin
                    calNoRef_q <= 1'b1;
                end
            end else if (wrLow && avs_address == `REG_STATUS && avs_writedata[`STAT_CALNOREF_BIT]) begin
                calNoRef_q <= 1'b0; // write one clears; a same-cycle set wins above
            end
        end
    end

    // read data registered together with the wait drop
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read & avs_waitrequest) begin
            case (avs_address)
                `REG_CTRL: begin
                    avs_readdata <= {30'h00000000, scalerHighBand, doublerEnable_q};
                end
                `REG_PREDIV: begin
                    avs_readdata <= {24'h000000, preDiv_q};
                end
                `REG_SCALER: begin
                    avs_readdata <= {29'h00000000, scalerFactor_q};
                end
                `REG_POSTDIV: begin
                    avs_readdata <= {24'h000000, postDiv_q};
                end
                `REG_STATUS: begin
                    // conflict shows the doubler and scaler both selected
                    avs_readdata <= {29'h00000000, calNoRef_q,
                        doublerEnable_q & scalerActive, refOk_q};
                end
                default: begin
                    avs_readdata <= 32'h00000000; // unmapped reads zero
                end
            endcase
        end
    end
endmodule

//--- hw/tick_divider.v
`timescale 1ns/100ps
`include "ref_path_consts.vh"

// divides a stream of one-cycle ticks by an 8-bit value
module tick_divider #(
    parameter DIV_W = 8
) (
    input wire clk_sys,
    input wire rst_b,
    input wire tickIn,
    input wire [DIV_W-1:0] divValue,
    output reg tickOut
);
    reg [DIV_W-1:0] count_q; // ticks seen in current output period
    reg [DIV_W-1:0] div_q; // divisor in force for current period
    wire [DIV_W-1:0] divEff; // zero behaves as bypass
    wire lastTick; // this tick closes the period

    assign divEff = (div_q == {DIV_W{1'b0}}) ? `DIV_ONE : div_q;
    assign lastTick = (count_q >= divEff - `DIV_ONE);

    // count ticks; new divisor is taken only at a period boundary so no runt appears
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= {DIV_W{1'b0}};
            div_q <= `DIV_ONE;
            tickOut <= 1'b0;
        end else begin
            tickOut <= 1'b0;
            if (tickIn) begin
                if (lastTick) begin
                    tickOut <= 1'b1;
                    count_q <= {DIV_W{1'b0}};
                    div_q <= divValue;
                end else begin
                    count_q <= count_q + `DIV_ONE;
                end
            end
        end
    end
endmodule

//--- inc/ref_path_consts.vh
`ifndef REF_PATH_CONSTS_VH
`define REF_PATH_CONSTS_VH

// register byte offsets, one aligned word each
`define REG_CTRL 5'h00
`define REG_PREDIV 5'h04
`define REG_SCALER 5'h08
`define REG_POSTDIV 5'h0C
`define REG_STATUS 5'h10

// control register fields
`define CTRL_DOUBLER_BIT 0
`define CTRL_HIBAND_BIT 1
`define CTRL_CALTRIG_BIT 2

// status register fields
`define STAT_REFOK_BIT 0
`define STAT_CONFLICT_BIT 1
`define STAT_CALNOREF_BIT 2

// reset values and scaler factor limits
`define PREDIV_RESET 8'h01
`define POSTDIV_RESET 8'h01
`define SCALER_RESET 3'h1
`define DIV_ONE 8'h01
`define SCALER_ONE 3'h1
`define SCALER_MIN 3'h3
`define SCALER_MAX 3'h7

// reference presence timeout, 125 MHz system clock
`define CLK_PERIOD_PS 8000
`define REF_TIMEOUT_NS 1000
`define REF_TIMEOUT_CYC ((`REF_TIMEOUT_NS * 1000) / `CLK_PERIOD_PS)

`endif

//--- sim/ref_clock_source.sv
`timescale 1ns/100ps
// reference oscillator model; zero half period parks it low as a missing source
module ref_clock_source (
    input wire clk_sys,
    input wire [7:0] halfCycles,
    output reg refClk
);
    integer cnt = 0; // cycles into this half period
    initial refClk = 1'b0;
    // equal high and low halves, so both edges are evenly spaced
    always @(posedge clk_sys) begin
        if (halfCycles == 8'h00) begin
            refClk <= 1'b0;
            cnt <= 0;
        end else if (cnt + 1 >= halfCycles) begin
            refClk <= ~refClk;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

//--- sim/reference_clock_path_chk.sv
`timescale 1ns/100ps
// passive watcher on the block's ports
module reference_clock_path_chk #(
    parameter TIMEOUT_CYC = 125
) (
    input wire clk_sys,
    input wire rst_b,
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire phaseCompareClk,
    input wire scalerHighBand,
    input wire calibrationStart
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // control write at the edge that accepts it
    wire ctrlWr = avs_write & ~avs_waitrequest & (avs_address == 5'h00) & avs_byteenable[0];
    AST_ONE_WAIT: assert property ((avs_read | avs_write) & avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer not one cycle late");
    AST_WAIT_BACK: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    AST_NO_SPUR_ACK: assert property (!(avs_read | avs_write) & avs_waitrequest |=> avs_waitrequest)
        else $error("answer without request");
    AST_UNMAPPED_ZERO: assert property (avs_read & !avs_waitrequest & (avs_address > 5'h10) |-> avs_readdata == 0)
        else $error("unmapped read not zero");
    AST_PULSE_SINGLE: assert property (phaseCompareClk |=> !phaseCompareClk)
        else $error("compare pulse longer than one cycle");
    AST_BAND_FOLLOWS: assert property (ctrlWr |=> ##1 scalerHighBand == $past(avs_writedata[1], 2))
        else $error("high band pin mismatch");
    AST_CAL_CAUSE: assert property (calibrationStart |-> $past(ctrlWr & avs_writedata[2]))
        else $error("calibration start without trigger");
    AST_CAL_SHORT: assert property (calibrationStart |=> !calibrationStart)
        else $error("calibration start too long");
    AST_RESET_QUIET: assert property ($rose(rst_b) |-> avs_waitrequest & !phaseCompareClk & !calibrationStart)
        else $error("outputs busy after reset");
    COV_CAL: cover property (calibrationStart);
    COV_BAND: cover property (phaseCompareClk & scalerHighBand);
    COV_WRITE: cover property (ctrlWr);
endmodule

//--- sim/reference_clock_path_tb_top.sv
`timescale 1ns/100ps
module reference_clock_path_tb_top;
    reg clk_sys = 1'b0; // system clock
    reg rst_b = 1'b0; // held low at start
    reg [4:0] avs_address = 5'h00;
    reg avs_read = 1'b0;
    reg avs_write = 1'b0;
    reg [31:0] avs_writedata = 32'h0;
    reg [3:0] avs_byteenable = 4'hF;
    reg [7:0] halfCycles = 8'h1E; // reference half period in clk_sys cycles
    reg [31:0] rd; // last read data
    wire [31:0] avs_readdata;
    wire avs_waitrequest, referenceClockInput, phaseCompareClk, scalerHighBand, calibrationStart;
    integer bad_count = 0;
    integer compares = 0;
    integer seed = 32'hBB63;
    integer i;
    always #4 clk_sys = ~clk_sys; // 125 MHz
    ref_clock_source src (.clk_sys(clk_sys), .halfCycles(halfCycles), .refClk(referenceClockInput));
    // short presence timeout keeps the absent-reference case quick
    reference_clock_path #(.TIMEOUT_CYC(32)) uut (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .referenceClockInput(referenceClockInput),
        .phaseCompareClk(phaseCompareClk), .scalerHighBand(scalerHighBand), .calibrationStart(calibrationStart));
    task give_verdict;
        begin
            $display("counts: %0d compares, %0d mismatches", compares, bad_count);
            if (bad_count == 0 && compares > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task check(input [31:0] exp, input [31:0] got, input [8*16:1] what);
        begin
            compares = compares + 1;
            if (exp !== got) begin
                bad_count = bad_count + 1;
                $display("unexpected %0s: expected %0h seen %0h", what, exp, got);
            end
        end
    endtask
    // one bus access; held until waitrequest is sampled low
    task bus(input wr, input [4:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clk_sys);
            avs_address <= a;
            avs_writedata <= d;
            avs_write <= wr;
            avs_read <= ~wr;
            n = 0;
            @(posedge clk_sys);
            // no cycle limit here: only the watchdog ends a stuck wait
            while (avs_waitrequest !== 1'b0) begin
                n = n + 1;
                @(posedge clk_sys);
            end
            check(1, n, "bus wait cycles");
            rd = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
        end
    endtask
    // cycles from one compare pulse to the k-th pulse after it
    task span(input integer k, output integer cyc);
        integer n;
        begin
            n = 0;
            cyc = -1;
            while (k >= 0 && n < 20000) begin
                @(posedge clk_sys);
                n = n + 1;
                if (cyc >= 0) cyc = cyc + 1;
                if (phaseCompareClk === 1'b1) begin
                    if (cyc < 0) cyc = 0;
                    k = k - 1;
                end
            end
        end
    endtask
    // program one path setting and compare four periods with the model
    task runCfg(input integer dbl, input integer pre, input integer fac, input integer post, input integer half);
        integer cyc, m, exp;
        begin
            halfCycles <= half[7:0]; // reference kept slow, so every stage stays in range
            bus(1, 5'h00, dbl);
            bus(1, 5'h04, pre);
            bus(1, 5'h08, fac);
            bus(1, 5'h0C, post);
            span(3, cyc); // old periods and the first scaled period run out
            span(4, cyc);
            m = (fac < 3) ? 1 : fac; // unused factors act as bypass
            exp = 8 * half * pre * post / ((dbl + 1) * m);
            check(exp, cyc, "compare span");
            $display("test path %0d %0d %0d %0d done", dbl, pre, fac, post);
        end
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            bus(0, {i[2:0], 2'b00}, 32'h0);
            check(i != 0, rd & 32'hFF, "reset value");
        end
        bus(0, 5'h14, 32'h0);
        check(0, rd, "unmapped read");
        avs_byteenable <= 4'hE; // lane 0 off, so the write must be dropped
        bus(1, 5'h04, 32'h55);
        avs_byteenable <= 4'hF;
        bus(0, 5'h04, 32'h0);
        check(1, rd & 32'hFF, "masked write");
        $display("test reset values done");
        runCfg(0, 1, 1, 1, 30);
        runCfg(1, 1, 1, 1, 30);
        runCfg(0, 3, 1, 2, 5);
        for (i = 3; i < 7; i = i + 1) runCfg(0, 1, i, 1, 30);
        runCfg(0, 1, 7, 1, 35);
        runCfg(0, 2, 6, 3, 30);
        runCfg(0, 1, 2, 1, 30);
        runCfg(0, 255, 1, 1, 2);
        runCfg(0, 1, 1, 255, 2);
        runCfg(0, 1 + {$random(seed)} % 8, 1, 1 + {$random(seed)} % 4, 4);
        bus(1, 5'h00, 32'h6);
        @(posedge clk_sys);
        check(1, calibrationStart, "cal start");
        @(posedge clk_sys);
        check(1, scalerHighBand, "high band");
        bus(1, 5'h08, 32'h5);
        halfCycles <= 8'h00; // source goes away
        repeat (40) @(posedge clk_sys);
        bus(1, 5'h00, 32'h5);
        @(posedge clk_sys);
        check(0, calibrationStart, "cal no ref");
        bus(0, 5'h10, 32'h0);
        check(6, rd & 7, "status");
        bus(1, 5'h10, 32'h4);
        bus(0, 5'h10, 32'h0);
        check(2, rd & 7, "status clear");
        $display("test calibration done");
        give_verdict;
    end
    // hang guard, well beyond the expected run length
    initial begin
        repeat (80000) @(posedge clk_sys);
        bad_count = bad_count + 1;
        give_verdict;
    end
endmodule
bind reference_clock_path reference_clock_path_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (.clk_sys(clk_sys),
    .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .phaseCompareClk(phaseCompareClk), .scalerHighBand(scalerHighBand),
    .calibrationStart(calibrationStart));
